// File: rtl/smp_pkg.sv
package smp_pkg;
  localparam int          HDR_BYTES     = 4;
  localparam logic [1:0]  POS_KIND      = 2'h0;
  localparam logic [1:0]  POS_FLAGS     = 2'h1;
  localparam logic [1:0]  POS_LEN_A     = 2'h2;
  localparam logic [1:0]  POS_LEN_B     = 2'h3;
  localparam int          FLAG_ORDER    = 0;
  localparam logic [15:0] LEN_REST      = 16'h0000;
  localparam logic [7:0]  KIND_EXT_LO   = 8'h80;
  localparam logic [7:0]  KIND_VEND_LO  = 8'hC0;
  localparam logic [7:0]  KIND_KNOWN_HI = 8'h7F;
  localparam logic [7:0]  KIND_CTX      = 8'h0C;
  localparam logic [7:0]  CTX_INIT      = 8'h00;
  localparam logic [1:0]  MAJOR_VERSION = 2'h2;
  typedef enum logic [3:0] {
    SMP_IDLE = 4'h1,
    SMP_HDR  = 4'h2,
    SMP_BODY = 4'h4,
    SMP_DROP = 4'h8
  } smp_state_type;
endpackage

// File: rtl/smp_hdr_dec.sv
`timescale 1ns/1ns
`default_nettype none
// Combinational decode of three captured header bytes and the live fourth.
module smp_hdr_dec
  import smp_pkg::*;
(
  input  wire logic [7:0]  kind,
  input  wire logic [7:0]  flags,
  input  wire logic [7:0]  len_a,
  input  wire logic [7:0]  len_b,
  output logic             little,
  output logic [15:0]      body_len,
  output logic             known,
  output logic [6:0]       kind_flags
);
  // Byte order picks how the two length bytes combine.
  always_comb begin
    little     = flags[FLAG_ORDER];
    body_len   = little ? {len_b, len_a} : {len_a, len_b};
    known      = (kind <= KIND_KNOWN_HI);
    kind_flags = known ? flags[7:1] : 7'h00;
  end
endmodule
`default_nettype wire

// File: rtl/smp_parser.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Each part starts with a fixed header followed by body elements.
// - Kind code from header selects how the part is interpreted.
// - Header carries eight individually decoded flags; the code decodes only flag zero and passes flags one to seven as one field for known kinds, zero for others.
// - Flag zero is the byte order flag in every kind.
// - Byte order flag clear means big endian, set means little endian.
// - Flags one to seven are interpreted per decoded kind.
// - Length counts only the body, unsigned sixteen bits.
// - Nonzero length locates the next header after that many body bytes.
// - Final part may carry length equal to remaining message bytes.
// - Zero length marks final part extending to message end.
// - Context from earlier parts applies to later parts of the message.
// - Context resets to initial values at each new message.
// - Framing layout fixed for major version two; only new kinds added.
// - Kind space keeps extension and vendor ranges.
// - A truncated header invalidates the rest of the message.
// - An invalid length discards the rest of the message.
// - Unknown kinds are skipped by length and parsing continues.
// - Unknown or unused flags are ignored, never rejected.
module smp_parser
  import smp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        msg_start,
  input  wire logic [31:0] msg_length,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  output logic             part_valid,
  output logic [7:0]       part_kind_code,
  output logic [6:0]       part_flags,
  output logic             byte_order_flag,
  output logic [15:0]      body_length_field,
  output logic             part_last,
  output logic             part_known,
  output logic             body_valid,
  output logic [7:0]       body_data,
  output logic             body_end,
  output logic [7:0]       context_value,
  output logic             msg_error,
  output logic             msg_done
);
  smp_state_type state;
  smp_state_type next_state;
  logic [31:0]   remain;
  logic [31:0]   next_remain;
  logic [31:0]   body_cnt;
  logic [31:0]   next_body_cnt;
  logic [1:0]    hpos;
  logic [1:0]    next_hpos;
  logic [7:0]    hb [4];
  logic [7:0]    next_hb [4];
  logic [7:0]    ctx;
  logic [7:0]    next_ctx;
  logic          dec_little;
  logic [15:0]   dec_len;
  logic          dec_known;
  logic [6:0]    dec_flags;
  logic [7:0]    last_byte;
  logic          next_part_valid;
  logic          next_part_last;
  logic          next_body_valid;
  logic          next_body_end;
  logic          next_msg_error;
  logic          next_msg_done;

  // The fourth header byte is decoded as it arrives so no extra cycle is spent.
  always_comb begin
    last_byte = in_data;
  end

  smp_hdr_dec u_dec (
    .kind       (hb[POS_KIND]),
    .flags      (hb[POS_FLAGS]),
    .len_a      (hb[POS_LEN_A]),
    .len_b      (last_byte),
    .little     (dec_little),
    .body_len   (dec_len),
    .known      (dec_known),
    .kind_flags (dec_flags)
  );

  // Framing walk: header bytes, then the body counted down, then the next header.
  always_comb begin
    next_state      = state;
    next_remain     = remain;
    next_body_cnt   = body_cnt;
    next_hpos       = hpos;
    next_hb         = hb;
    next_ctx        = ctx;
    next_part_valid = 1'b0;
    next_part_last  = part_last;
    next_body_valid = 1'b0;
    next_body_end   = 1'b0;
    next_msg_error  = 1'b0;
    next_msg_done   = 1'b0;
    if (msg_start) begin
      next_state  = (msg_length == 32'h0) ? SMP_IDLE : SMP_HDR;
      next_remain = msg_length;
      next_hpos   = 2'h0;
      next_ctx    = CTX_INIT;
    end else if (in_valid && remain != 32'h0) begin
      next_remain = remain - 32'h1;
      case (state)
        SMP_HDR: begin
          next_hb[hpos] = in_data;
          next_hpos     = hpos + 2'h1;
          if (hpos == POS_LEN_B) begin
            next_part_valid = 1'b1;
            next_part_last  = (dec_len == LEN_REST) || (32'(dec_len) == remain - 32'h1);
            if (dec_len == LEN_REST) begin
              next_body_cnt = remain - 32'h1;
            end else begin
              next_body_cnt = 32'(dec_len);
            end
            if (dec_len != LEN_REST && 32'(dec_len) > remain - 32'h1) begin
              next_state     = SMP_DROP;
              next_msg_error = 1'b1;
            end else if (next_body_cnt == 32'h0) begin
              next_state    = (remain == 32'h1) ? SMP_IDLE : SMP_HDR;
              next_msg_done = (remain == 32'h1);
            end else begin
              next_state = SMP_BODY;
            end
            if (dec_known && hb[POS_KIND] == KIND_CTX) begin
              next_ctx = hb[POS_FLAGS];
            end
          end else if (remain == 32'h1) begin
            next_state     = SMP_IDLE;
            next_msg_error = 1'b1;
          end
        end
        SMP_BODY: begin
          next_body_valid = 1'b1;
          next_body_cnt   = body_cnt - 32'h1;
          if (body_cnt == 32'h1) begin
            next_body_end = 1'b1;
            next_hpos     = 2'h0;
            next_state    = (remain == 32'h1) ? SMP_IDLE : SMP_HDR;
            next_msg_done = (remain == 32'h1);
          end
        end
        SMP_DROP: begin
          if (remain == 32'h1) begin
            next_state = SMP_IDLE;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // Output registers; a new header is only published on the second length byte.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state             <= SMP_IDLE;
      remain            <= 32'h0;
      body_cnt          <= 32'h0;
      hpos              <= 2'h0;
      hb                <= '{default: 8'h00};
      ctx               <= CTX_INIT;
      part_valid        <= 1'b0;
      part_kind_code    <= 8'h00;
      part_flags        <= 7'h00;
      byte_order_flag   <= 1'b0;
      body_length_field <= 16'h0000;
      part_last         <= 1'b0;
      part_known        <= 1'b0;
      body_valid        <= 1'b0;
      body_data         <= 8'h00;
      body_end          <= 1'b0;
      context_value     <= CTX_INIT;
      msg_error         <= 1'b0;
      msg_done          <= 1'b0;
    end else begin
      state         <= next_state;
      remain        <= next_remain;
      body_cnt      <= next_body_cnt;
      hpos          <= next_hpos;
      hb            <= next_hb;
      ctx           <= next_ctx;
      part_valid    <= next_part_valid;
      part_last     <= next_part_last;
      body_valid    <= next_body_valid;
      body_end      <= next_body_end;
      msg_error     <= next_msg_error;
      msg_done      <= next_msg_done;
      context_value <= ctx;
      if (next_body_valid) begin
        body_data <= in_data;
      end
      if (next_part_valid) begin
        part_kind_code    <= hb[POS_KIND];
        part_flags        <= dec_flags;
        byte_order_flag   <= dec_little;
        body_length_field <= dec_len;
        part_known        <= dec_known;
      end
    end
  end

  // The last header byte must publish the part on part_valid one cycle later.
  a_hdr_publish: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == SMP_HDR && in_valid && !msg_start && hpos == POS_LEN_B && remain != 32'h0)
    |=> part_valid) else $error("header not published");
  a_new_ctx: assert property (@(posedge clk_sys) disable iff (!reset_n)
    msg_start |=> ctx == CTX_INIT) else $error("context not reset");
  a_order_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
    part_valid && !byte_order_flag |-> body_length_field == {$past(hb[POS_LEN_A]), $past(in_data)})
    else $error("big endian length wrong");
  a_bad_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
    msg_error |-> state != SMP_BODY) else $error("body after error");
  a_short_hdr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == SMP_HDR && in_valid && !msg_start && remain == 32'h1 && hpos != POS_LEN_B)
    |=> msg_error && state == SMP_IDLE) else $error("truncated header kept");
  a_body_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == SMP_BODY && in_valid && !msg_start && body_cnt == 32'h1 && remain > 32'h1)
    |=> body_end && state == SMP_HDR) else $error("next header missed");
  a_zero_last: assert property (@(posedge clk_sys) disable iff (!reset_n)
    part_valid && body_length_field == LEN_REST |-> part_last) else $error("zero not last");
  a_exact_last: assert property (@(posedge clk_sys) disable iff (!reset_n)
    part_valid && 32'(body_length_field) == remain |-> part_last) else $error("final missed");
  c_two_parts: cover property (@(posedge clk_sys) disable iff (!reset_n)
    part_valid ##[1:40] part_valid);
  c_error: cover property (@(posedge clk_sys) disable iff (!reset_n) msg_error);
  c_done: cover property (@(posedge clk_sys) disable iff (!reset_n) part_last ##[1:40] msg_done);
  // Extension and vendor kinds must never be taken for kinds this parser knows.
  a_kind_space: assert property (@(posedge clk_sys) disable iff (!reset_n)
    part_valid && part_kind_code >= KIND_EXT_LO |-> !part_known) else $error("reserved kind known");
  c_vendor: cover property (@(posedge clk_sys) disable iff (!reset_n)
    part_valid && part_kind_code >= KIND_VEND_LO);
endmodule
`default_nettype wire

// File: tb/smp_transport.sv
`timescale 1ns/1ns
`default_nettype none
// Transport side: hands over one whole message of known length, byte by byte.
module smp_transport (
  input  wire logic        clk_sys,
  output logic             msg_start,
  output logic [31:0]      msg_length,
  output logic             in_valid,
  output logic [7:0]       in_data
);
  // Idle values at time zero.
  initial begin
    msg_start = 1'b0;
    msg_length = 32'h0;
    in_valid = 1'b0;
    in_data = 8'h00;
  end
  // Each message is sent whole, the parts built by the bench with their lengths set.
  // A stall scrambles the data line, so a stale byte is never mistaken for a new one.
  task automatic send(input logic [7:0] m[$], input logic [31:0] gaps);
    @(negedge clk_sys);
    msg_start = 1'b1;
    msg_length = 32'(m.size());
    @(negedge clk_sys);
    msg_start = 1'b0;
    foreach (m[i]) begin
      if (gaps[i % 32]) begin
        in_valid = 1'b0;
        in_data = ~in_data;
        @(negedge clk_sys);
      end
      in_valid = 1'b1;
      in_data = m[i];
      @(negedge clk_sys);
    end
    in_valid = 1'b0;
    in_data = ~in_data;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import smp_pkg::*;
  logic        clk_sys, reset_n, msg_start, in_valid, part_valid, byte_order_flag, part_last;
  logic        part_known, body_valid, body_end, msg_error, msg_done;
  logic [31:0] msg_length, seed;
  logic [7:0]  in_data, part_kind_code, body_data, context_value;
  logic [6:0]  part_flags;
  logic [15:0] body_length_field;
  logic [7:0]  m[$], eb[$], gb[$];
  logic [33:0] eh[$], gh[$];
  int          fails, checked, ee, gd, gr, ne, gn;
  smp_transport smp_transport_i (.clk_sys(clk_sys), .msg_start(msg_start),
    .msg_length(msg_length), .in_valid(in_valid), .in_data(in_data));
  smp_parser smp_parser_i (.clk_sys(clk_sys), .reset_n(reset_n), .msg_start(msg_start),
    .msg_length(msg_length), .in_valid(in_valid), .in_data(in_data),
    .part_valid(part_valid), .part_kind_code(part_kind_code), .part_flags(part_flags),
    .byte_order_flag(byte_order_flag), .body_length_field(body_length_field),
    .part_last(part_last), .part_known(part_known), .body_valid(body_valid),
    .body_data(body_data), .body_end(body_end), .context_value(context_value),
    .msg_error(msg_error), .msg_done(msg_done));
  // Clock at 250 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Monitor collects every pulse; outputs are registered, so the edge sees settled values.
  always @(posedge clk_sys) begin
    if (reset_n && part_valid) gh.push_back({part_kind_code, part_flags, byte_order_flag,
      body_length_field, part_last, part_known});
    if (reset_n && body_valid) gb.push_back(body_data);
    if (reset_n && msg_done) gd++;
    if (reset_n && msg_error) gr++;
    if (reset_n && body_end) gn++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Appends one part; the length goes out in the order its own flag selects.
  task automatic add(input logic [7:0] k, f, input logic [15:0] l, input int n);
    m.push_back(k);
    m.push_back(f);
    m.push_back(f[0] ? l[7:0] : l[15:8]);
    m.push_back(f[0] ? l[15:8] : l[7:0]);
    repeat (n) m.push_back(8'(rnd()));
  endtask
  // Reference walk over the message: headers, body bytes and the closing status.
  function automatic void model();
    int p;
    int n;
    logic [15:0] l;
    p = 0;
    ee = 1;
    ne = 0;
    while (p < m.size()) begin
      if (m.size() - p < HDR_BYTES) begin
        ee = 2;
        return;
      end
      l = m[p+1][0] ? {m[p+3], m[p+2]} : {m[p+2], m[p+3]};
      n = (l == LEN_REST) ? m.size() - p - 4 : int'(l);
      // An overlong part is still announced before the rest of the message is dropped.
      eh.push_back({m[p], m[p] > KIND_KNOWN_HI ? 7'h00 : m[p+1][7:1], m[p+1][0], l,
        p + 4 + n == m.size(), m[p] <= KIND_KNOWN_HI});
      if (p + 4 + n > m.size()) begin
        ee = 2;
        return;
      end
      if (n > 0) ne++;
      for (int i = 0; i < n; i++) eb.push_back(m[p+4+i]);
      p += 4 + n;
    end
  endfunction
  task automatic cmp_hdr(input logic [33:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected header at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Sends the built message and compares the headers, body bytes and status pulses the parser reported for it.
  task automatic run(input logic [31:0] gaps);
    eh.delete(); eb.delete(); gh.delete(); gb.delete();
    gd = 0;
    gr = 0;
    gn = 0;
    model();
    smp_transport_i.send(m, gaps);
    repeat (6) @(negedge clk_sys);
    cmp_byte(8'(gh.size()), 8'(eh.size()));
    foreach (eh[i]) cmp_hdr(gh[i], eh[i]);
    cmp_byte(8'(gb.size()), 8'(eb.size()));
    foreach (eb[i]) cmp_byte(gb[i], eb[i]);
    cmp_byte({4'(gr), 4'(gd)}, ee == 1 ? 8'h01 : 8'h10);
    cmp_byte(8'(gn), 8'(ne));
    m.delete();
  endtask
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog sized well above the under two thousand cycles the sequence needs.
  initial begin
    #80000;
    fails++;
    print_verdict();
  end
  initial begin
    seed = 32'h00006960;
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    add(8'h01, 8'h00, 16'h0002, 2); add(8'h07, 8'hFE, 16'h0003, 3); run(32'h0);
    add(8'h05, 8'h01, 16'h0004, 4); add(8'h06, 8'h03, 16'h0000, 5); run(rnd());
    add(8'h90, 8'hFF, 16'h0002, 2); add(8'hC3, 8'h02, 16'h0001, 1);
    add(8'h02, 8'h00, 16'h0000, 3); run(32'h0);
    add(8'h0C, 8'hA4, 16'h0001, 1); add(8'h03, 8'h00, 16'h0000, 2); run(32'h0);
    cmp_byte(context_value, 8'hA4);
    add(8'h03, 8'h00, 16'h0002, 2); m.push_back(8'h01); m.push_back(8'h00); run(32'h0);
    cmp_byte(context_value, CTX_INIT);
    add(8'h04, 8'h00, 16'h0009, 3); run(rnd());
    // Random messages: one to three parts, the last closed by zero or exact length.
    repeat (20) begin
      for (int k = int'(rnd() % 3); k >= 0; k--) begin
        ee = 1 + int'(rnd() % 6);
        add(8'(rnd()), 8'(rnd()), (k == 0 && rnd() % 2 == 0) ? 16'h0000 : 16'(ee), ee);
      end
      run(rnd());
    end
    print_verdict();
  end
endmodule
`default_nettype wire
